// ===== hw/tle_exec.sv
// Purpose: execution of translate-test and list instructions (push, pop, up)
// Assumes: memory answers a read with rd_valid one or more cycles later
// Notes:   push limit check uses a limit pointer supplied by the caller
//
// Behaviour
// RULE1 - clear byte counter before first table access
// RULE2 - table address = start plus leftmost B byte
// RULE3 - odd entry address: branch and mark
// RULE4 - even entry: next start, add word to A
// RULE5 - accumulator A never cleared by translate
// RULE6 - entry byte into B byte 0, rotate
// RULE7 - increment byte counter each pass
// RULE8 - after third pass, counter gets last word
// RULE9 - loop back with next B byte
// RULE10 - branch exit: counter holds byte number
// RULE11 - even new address chains into new table
// RULE12 - list ops leave condition codes alone
// RULE13 - cell: char bits 0-7, link 9-23
// RULE14 - zero link marks last character
// RULE15 - push writes only within stack limits
// RULE16 - pop loads A from top pointer
// RULE17 - pop: top equals base means empty
// RULE18 - pop: decrement top and skip
// RULE19 - up: char to A and B, zeros
// RULE20 - up: list pointer into B address
// RULE21 - up: store cell back, skip unless zero
// RULE22 - skip advances program pointer one extra
`timescale 1ns/1ps
`default_nettype none
module tle_exec
  import tle_pkg::*;
(
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset,
  // instruction start
  input  wire logic              start,
  input  wire tle_op_t           op,
  input  wire logic [ADDR_W-1:0] effective_addr,
  input  wire logic [ADDR_W-1:0] stack_base_ptr,
  input  wire logic [ADDR_W-1:0] stack_limit_ptr,
  input  wire tle_regs_t         regs_in,
  // memory
  output var  tle_mem_req_t      mem_req,
  input  wire logic              mem_rd_valid,
  input  wire logic [WORD_W-1:0] mem_rdata,
  // results
  output var  logic              done,
  output var  logic              branch_and_mark,
  output var  logic              cc_write,
  output var  logic [WORD_W-1:0] accumulator_a,
  output var  logic [WORD_W-1:0] operand_reg_b,
  output var  logic [WORD_W-1:0] byte_counter_index,
  output var  logic [ADDR_W-1:0] program_pointer,
  output var  logic [ADDR_W-1:0] branch_addr
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_PTR_RD, ST_WAIT_PTR, ST_DATA_RD, ST_WAIT_DATA, ST_WRITE, ST_DONE
  } tle_state_t;

  tle_state_t        state_q;
  tle_op_t           op_q;
  logic [ADDR_W-1:0] start_q;
  logic [ADDR_W-1:0] ptr_q;
  logic [1:0]        pass_q;
  logic              skip_q;
  logic              word_load;
  logic [WORD_W-1:0] word_q;

  tle_word_reg u_word (
    .ref_clk (ref_clk),
    .reset   (reset),
    .load    (word_load),
    .din     (mem_rdata),
    .dout    (word_q)
  );

  assign word_load = mem_rd_valid && (state_q == ST_WAIT_DATA || state_q == ST_WAIT_PTR);

  // translate lookup of the current leftmost B byte, carry into the address
  logic [ADDR_W-1:0] tbl_addr;
  assign tbl_addr = start_q + {7'h00, operand_reg_b[23:16]}; // [RULE2] [RULE11]

  logic [ADDR_W-1:0] rd_link;
  assign rd_link = mem_rdata[ADDR_W-1:0];

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q <= ST_IDLE;
      op_q    <= TLE_OP_XLAT;
      start_q <= '0;
      ptr_q   <= '0;
      pass_q  <= '0;
      skip_q  <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            op_q    <= op;
            start_q <= effective_addr;
            pass_q  <= '0;
            skip_q  <= 1'b0;
            // translate reads the table directly; list ops read the pointer word first
            state_q <= (op == TLE_OP_XLAT) ? ST_DATA_RD : ST_PTR_RD;
          end
        end
        ST_PTR_RD: state_q <= ST_WAIT_PTR;
        ST_WAIT_PTR: begin
          if (mem_rd_valid) begin
            ptr_q <= rd_link;
            case (op_q)
              TLE_OP_PUSH: begin
                // room left only while top stays below the limit
                if (rd_link < stack_limit_ptr) begin // [RULE15]
                  state_q <= ST_WRITE;
                end else begin
                  state_q <= ST_DONE;
                end
              end
              TLE_OP_UP: begin
                if (rd_link == ZERO_ADDR) begin // [RULE14] [RULE21]
                  state_q <= ST_DONE;
                end else begin
                  state_q <= ST_DATA_RD;
                end
              end
              default: state_q <= ST_DATA_RD;
            endcase
          end
        end
        ST_DATA_RD: state_q <= ST_WAIT_DATA;
        ST_WAIT_DATA: begin
          if (mem_rd_valid) begin
            case (op_q)
              TLE_OP_XLAT: begin
                if (rd_link[0]) begin // [RULE3]
                  state_q <= ST_DONE;
                end else begin
                  start_q <= rd_link; // [RULE4] [RULE11]
                  pass_q  <= pass_q + 2'h1;
                  if (pass_q + 2'h1 == XLAT_PASSES) begin // [RULE8]
                    state_q <= ST_DONE;
                  end else begin
                    state_q <= ST_DATA_RD; // [RULE9]
                  end
                end
              end
              TLE_OP_POP: begin
                if (ptr_q != stack_base_ptr) begin // [RULE17]
                  skip_q  <= 1'b1; // [RULE18]
                  state_q <= ST_WRITE;
                end else begin
                  state_q <= ST_DONE;
                end
              end
              TLE_OP_UP: begin
                skip_q  <= 1'b1; // [RULE21]
                state_q <= ST_WRITE;
              end
              default: state_q <= ST_DONE;
            endcase
          end
        end
        ST_WRITE: state_q <= ST_DONE;
        ST_DONE:  state_q <= ST_IDLE;
        default:  state_q <= ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // memory requests
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mem_req <= '0;
    end else begin
      mem_req <= '0;
      if (state_q == ST_IDLE && start && op == TLE_OP_XLAT) begin
        // first lookup waits for the registers to load, issued from ST_DATA_RD
        mem_req <= '0;
      end else if (state_q == ST_PTR_RD) begin
        mem_req.valid <= 1'b1;
        mem_req.addr  <= start_q;
      end else if (state_q == ST_DATA_RD) begin
        mem_req.valid <= 1'b1;
        mem_req.addr  <= (op_q == TLE_OP_XLAT) ? tbl_addr : ptr_q; // [RULE16]
      end else if (state_q == ST_WRITE) begin
        mem_req.valid <= 1'b1;
        mem_req.write <= 1'b1;
        case (op_q)
          TLE_OP_PUSH: begin
            // store A at the next slot, then the pointer word is bumped by software
            mem_req.addr  <= ptr_q + 15'h0001;
            mem_req.wdata <= accumulator_a;
          end
          TLE_OP_POP: begin
            mem_req.addr  <= start_q;
            mem_req.wdata <= {9'h000, ptr_q - 15'h0001}; // [RULE18]
          end
          default: begin
            mem_req.addr  <= start_q;
            mem_req.wdata <= word_q; // [RULE21]
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // register results
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      accumulator_a      <= '0;
      operand_reg_b      <= '0;
      byte_counter_index <= '0;
    end else if (state_q == ST_IDLE && start) begin
      accumulator_a      <= regs_in.acc_a; // [RULE5]
      operand_reg_b      <= regs_in.reg_b;
      byte_counter_index <= (op == TLE_OP_XLAT) ? '0 : regs_in.index; // [RULE1]
    end else if (state_q == ST_WAIT_DATA && mem_rd_valid) begin
      case (op_q)
        TLE_OP_XLAT: begin
          if (!rd_link[0]) begin
            accumulator_a <= accumulator_a + mem_rdata; // [RULE4]
            // byte 0 replaced then rotate left 8
            operand_reg_b <= {operand_reg_b[15:0], mem_rdata[23:16]}; // [RULE6]
            if (pass_q + 2'h1 == XLAT_PASSES) begin
              byte_counter_index <= mem_rdata; // [RULE8] [RULE10]
            end else begin
              byte_counter_index <= byte_counter_index + 24'h000001; // [RULE7]
            end
          end
        end
        TLE_OP_POP: accumulator_a <= mem_rdata; // [RULE16]
        TLE_OP_UP: begin
          // char bits 0-7 to A and B, pointer into B address part
          accumulator_a <= {mem_rdata[23:16], 16'h0000}; // [RULE13] [RULE19]
          operand_reg_b <= {mem_rdata[23:16], 1'b0, ptr_q}; // [RULE20]
        end
        default: accumulator_a <= accumulator_a;
      endcase
    end else if (state_q == ST_WAIT_PTR && mem_rd_valid && op_q == TLE_OP_UP
                 && rd_link == ZERO_ADDR) begin
      accumulator_a <= '0; // [RULE19]
      operand_reg_b <= {operand_reg_b[23:16], 1'b0, ZERO_ADDR}; // [RULE20]
    end
  end

  // ------------------------------------------------------------
  // completion and program pointer
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      done            <= 1'b0;
      branch_and_mark <= 1'b0;
      cc_write        <= 1'b0;
      program_pointer <= '0;
      branch_addr     <= '0;
    end else begin
      done            <= (state_q == ST_DONE);
      cc_write        <= 1'b0; // [RULE12]
      branch_and_mark <= 1'b0;
      if (state_q == ST_IDLE && start) begin
        program_pointer <= regs_in.pc + 15'h0001;
      end
      if (state_q == ST_WAIT_DATA && mem_rd_valid && op_q == TLE_OP_XLAT && rd_link[0]) begin
        branch_and_mark <= 1'b1; // [RULE3]
        branch_addr     <= rd_link;
      end
      if (state_q == ST_DONE && skip_q) begin
        program_pointer <= program_pointer + 15'h0001; // [RULE22]
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_cc_untouched: assert property (@(posedge ref_clk) disable iff (reset) // [RULE12]
    !cc_write) else $error("condition codes written");

  a_xlat_clear_idx: assert property (@(posedge ref_clk) disable iff (reset) // [RULE1]
    (state_q == ST_IDLE && start && op == TLE_OP_XLAT) |=> byte_counter_index == 24'h000000)
    else $error("index not cleared at translate start");

  a_xlat_acc_add: assert property (@(posedge ref_clk) disable iff (reset) // [RULE4]
    (state_q == ST_WAIT_DATA && mem_rd_valid && op_q == TLE_OP_XLAT && !mem_rdata[0])
    |=> accumulator_a == $past(accumulator_a) + $past(mem_rdata))
    else $error("translate entry not summed");

  a_xlat_rotate: assert property (@(posedge ref_clk) disable iff (reset) // [RULE6]
    (state_q == ST_WAIT_DATA && mem_rd_valid && op_q == TLE_OP_XLAT && !mem_rdata[0])
    |=> operand_reg_b[7:0] == $past(mem_rdata[23:16]))
    else $error("b not rotated with entry byte");

  // branch flag comes with the move to the done state, done follows one cycle later
  a_xlat_branch: assert property (@(posedge ref_clk) disable iff (reset) // [RULE3]
    (state_q == ST_WAIT_DATA && mem_rd_valid && op_q == TLE_OP_XLAT && mem_rdata[0])
    |=> branch_and_mark ##1 done) else $error("odd entry did not branch");

  a_pop_empty: assert property (@(posedge ref_clk) disable iff (reset) // [RULE17]
    (state_q == ST_WAIT_DATA && mem_rd_valid && op_q == TLE_OP_POP && ptr_q == stack_base_ptr)
    |=> !skip_q) else $error("empty pop skipped");

  a_pop_skip: assert property (@(posedge ref_clk) disable iff (reset) // [RULE22]
    (state_q == ST_DONE && skip_q) |=> program_pointer == $past(program_pointer) + 15'h0001)
    else $error("skip did not advance pointer");

  a_up_zero: assert property (@(posedge ref_clk) disable iff (reset) // [RULE19]
    (state_q == ST_WAIT_DATA && mem_rd_valid && op_q == TLE_OP_UP)
    |=> accumulator_a[15:0] == 16'h0000) else $error("up left stale bytes in a");

  a_push_limit: assert property (@(posedge ref_clk) disable iff (reset) // [RULE15]
    (state_q == ST_WAIT_PTR && mem_rd_valid && op_q == TLE_OP_PUSH
     && mem_rdata[14:0] >= stack_limit_ptr) |=> ##1 !mem_req.write)
    else $error("push wrote past limit");
endmodule
`default_nettype wire

// ===== hw/tle_word_reg.sv
// Purpose: one 24-bit holding register with registered output
// Assumes: synchronous active-high reset
// Notes:   holds the last fetched memory word for the sequencer
`timescale 1ns/1ps
`default_nettype none
module tle_word_reg
  import tle_pkg::*;
(
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset,
  // data
  input  wire logic              load,
  input  wire logic [WORD_W-1:0] din,
  output var  logic [WORD_W-1:0] dout
);
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      dout <= '0;
    end else if (load) begin
      dout <= din;
    end
  end
endmodule
`default_nettype wire

// ===== pkg/tle_pkg.sv
// Purpose: shared constants and carriers for the translate and list execution unit
// Assumes: 24-bit words, 15-bit addresses, big-endian bit numbering (bit 0 = msb)
// Notes:   architectural bit n is bit 23-n of a vector here
package tle_pkg;
  localparam int WORD_W  = 24;
  localparam int ADDR_W  = 15;
  localparam int CHAR_W  = 8;
  // character field: arch bits 0-7 -> [23:16]; address field: arch bits 9-23 -> [14:0]
  localparam int CHAR_LSB = 16;
  localparam int ADDR_LSB = 0;
  localparam logic [1:0] XLAT_PASSES = 2'h3;
  localparam logic [ADDR_W-1:0] ZERO_ADDR = 15'h0000;

  typedef enum logic [1:0] {
    TLE_OP_XLAT = 2'h0,
    TLE_OP_PUSH = 2'h1,
    TLE_OP_POP  = 2'h2,
    TLE_OP_UP   = 2'h3
  } tle_op_t;

  // memory request toward main memory
  typedef struct packed {
    logic                 valid;
    logic                 write;
    logic [ADDR_W-1:0]    addr;
    logic [WORD_W-1:0]    wdata;
  } tle_mem_req_t;

  // register file snapshot handed in at instruction start
  typedef struct packed {
    logic [WORD_W-1:0] acc_a;
    logic [WORD_W-1:0] reg_b;
    logic [WORD_W-1:0] index;
    logic [ADDR_W-1:0] pc;
  } tle_regs_t;
endpackage

// ===== verification/testbench.sv
// Purpose: self-checking bench for the translate and list execution unit
// Assumes: memory model on the far side, inputs driven on falling edges
// Notes:   expectations are worked out from the model memory contents
`timescale 1ns/1ps
`default_nettype none
module testbench
  import tle_pkg::*;
;
  logic ref_clk, reset, start, slow, mem_rd_valid, done, branch_and_mark, cc_write;
  tle_op_t           op;
  logic [ADDR_W-1:0] effective_addr, stack_base_ptr, stack_limit_ptr, program_pointer, branch_addr;
  tle_regs_t         regs_in;
  tle_mem_req_t      mem_req;
  logic [WORD_W-1:0] mem_rdata, accumulator_a, operand_reg_b, byte_counter_index;
  int                n_fail, tests_run;
  localparam logic [ADDR_W-1:0] PC = 15'h0040;

  tle_exec tle_exec_inst (.ref_clk(ref_clk), .reset(reset), .start(start), .op(op),
    .effective_addr(effective_addr), .stack_base_ptr(stack_base_ptr),
    .stack_limit_ptr(stack_limit_ptr), .regs_in(regs_in), .mem_req(mem_req),
    .mem_rd_valid(mem_rd_valid), .mem_rdata(mem_rdata), .done(done),
    .branch_and_mark(branch_and_mark), .cc_write(cc_write), .accumulator_a(accumulator_a),
    .operand_reg_b(operand_reg_b), .byte_counter_index(byte_counter_index),
    .program_pointer(program_pointer), .branch_addr(branch_addr));
  tle_mem_model tle_mem_model_inst (.ref_clk(ref_clk), .slow(slow), .mem_req(mem_req),
    .mem_rd_valid(mem_rd_valid), .mem_rdata(mem_rdata));

  // -----------------------------------------------------------------
  // shared tasks
  // -----------------------------------------------------------------
  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
    tests_run++;
    // an unknown expectation means the scenario reads memory it never set up
    if (got !== exp || $isunknown(exp)) begin
      n_fail++;
      $display("MISMATCH t=%0t %s got=%h exp=%h", $time, what, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("counts: comparisons=%0d mismatches=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // one instruction: start pulse, bounded wait for done or the branch exit
  task automatic run_op(input tle_op_t o, input logic [14:0] eff, input logic [14:0] lim,
                        input logic [23:0] a, input logic [23:0] b, output logic bm);
    int i;
    bm = 1'b0;
    op = o;
    effective_addr = eff;
    stack_limit_ptr = lim;
    regs_in = '{acc_a: a, reg_b: b, index: 24'h000777, pc: PC};
    start = 1'b1;
    @(negedge ref_clk);
    start = 1'b0;
    for (i = 0; i < 200 && done !== 1'b1 && bm !== 1'b1; i++) begin
      @(negedge ref_clk);
      if (branch_and_mark === 1'b1) bm = 1'b1;
    end
    if (i == 200) chk(24'h0, 24'h1, "no completion");
    repeat (4) @(negedge ref_clk);
  endtask

  // translate: reference walk over the table contents
  task automatic xlat_case(input logic [23:0] a, input logic [23:0] b, input string name);
    logic [14:0] st, bra;
    logic [23:0] w, exp_a, eb, ei;
    logic        br, bm;
    st = 15'h0100; exp_a = a; eb = b; ei = 24'h0; br = 1'b0; bra = 15'h0;
    for (int k = 0; k < 3 && !br; k++) begin
      w = tle_mem_model_inst.mem[15'(st + eb[23:16])];
      if (w[0]) begin
        br = 1'b1; bra = w[14:0]; ei = 24'(k);
      end else begin
        st = w[14:0]; exp_a = exp_a + w; eb = {eb[15:0], w[23:16]}; ei = ei + 24'h1;
        if (k == 2) ei = w;
      end
    end
    run_op(TLE_OP_XLAT, 15'h0100, 15'h0, a, b, bm);
    chk({23'h0, bm}, {23'h0, br}, "branch exit");
    chk(byte_counter_index, ei, "byte counter");
    if (br) chk({9'h0, branch_addr}, {9'h0, bra}, "branch addr");
    else begin
      chk(accumulator_a, exp_a, "acc sum");
      chk(operand_reg_b, eb, "reg b");
    end
    $display("test %s finished", name);
  endtask

  task automatic test_translate();
    tle_mem_model_inst.mem[15'h0103] = 24'h110180;
    tle_mem_model_inst.mem[15'h0185] = 24'h220100;
    tle_mem_model_inst.mem[15'h0107] = 24'h330100;
    tle_mem_model_inst.mem[15'h0109] = 24'h440103;
    xlat_case(24'h000010, 24'h030507, "translate chain");
    slow = 1'b1;
    // every byte of b must land on a table entry that was set up above
    xlat_case(24'hfffff0, 24'h070305, "translate slow wrap");
    slow = 1'b0;
    xlat_case(24'h000000, 24'h090707, "branch byte0");
    xlat_case(24'h000000, 24'h070907, "branch byte1");
    xlat_case(24'h000000, 24'h030509, "branch byte2");
  endtask

  task automatic test_stack();
    logic bm;
    tle_mem_model_inst.mem[15'h0200] = 24'h000305;
    tle_mem_model_inst.mem[15'h0305] = 24'habcdef;
    stack_base_ptr = 15'h0305;
    run_op(TLE_OP_POP, 15'h0200, 15'h0, 24'h0, 24'h0, bm);
    chk(accumulator_a, 24'habcdef, "pop empty data");
    chk({9'h0, program_pointer}, {9'h0, PC + 15'h1}, "pop empty pp");
    chk(tle_mem_model_inst.mem[15'h0200], 24'h000305, "pop empty ptr");
    stack_base_ptr = 15'h0300;
    run_op(TLE_OP_POP, 15'h0200, 15'h0, 24'h0, 24'h0, bm);
    chk(accumulator_a, 24'habcdef, "pop data");
    chk({9'h0, program_pointer}, {9'h0, PC + 15'h2}, "pop skip");
    chk({9'h0, tle_mem_model_inst.mem[15'h0200][14:0]}, 24'h000304, "pop dec");
    tle_mem_model_inst.mem[15'h0230] = 24'h000500;
    tle_mem_model_inst.mem[15'h0501] = 24'h5a5a5a;
    run_op(TLE_OP_PUSH, 15'h0230, 15'h0500, 24'h123456, 24'h0, bm);
    chk(tle_mem_model_inst.mem[15'h0501], 24'h5a5a5a, "push full");
    run_op(TLE_OP_PUSH, 15'h0230, 15'h0501, 24'h123456, 24'h0, bm);
    chk(tle_mem_model_inst.mem[15'h0501], 24'h123456, "push room");
    $display("test stack finished");
  endtask

  task automatic test_list();
    logic bm;
    tle_mem_model_inst.mem[15'h0210] = 24'h000400;
    tle_mem_model_inst.mem[15'h0400] = 24'h410420;
    tle_mem_model_inst.mem[15'h0220] = 24'h000000;
    run_op(TLE_OP_UP, 15'h0210, 15'h0, 24'hffffff, 24'h0, bm);
    chk(accumulator_a, 24'h410000, "up acc");
    chk(operand_reg_b, 24'h410400, "up reg b");
    chk(tle_mem_model_inst.mem[15'h0210], 24'h410420, "up store back");
    chk({9'h0, program_pointer}, {9'h0, PC + 15'h2}, "up skip");
    run_op(TLE_OP_UP, 15'h0220, 15'h0, 24'hffffff, 24'h0, bm);
    chk(accumulator_a, 24'h000000, "up empty acc");
    chk({9'h0, program_pointer}, {9'h0, PC + 15'h1}, "up empty pp");
    chk(tle_mem_model_inst.mem[15'h0220], 24'h000000, "up empty mem");
    $display("test list finished");
  endtask

  // -----------------------------------------------------------------
  // clock, reset, monitors, main sequence
  // -----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // condition codes must never be written by any of these instructions
  always @(negedge ref_clk) begin
    if (!reset && cc_write !== 1'b0) chk({23'h0, cc_write}, 24'h0, "cc write");
  end

  // the whole sequence needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    print_verdict();
  end

  initial begin
    n_fail = 0; tests_run = 0; reset = 1'b1; start = 1'b0; slow = 1'b0; op = TLE_OP_XLAT;
    effective_addr = 15'h0; stack_base_ptr = 15'h0; stack_limit_ptr = 15'h0;
    regs_in = '0;
    repeat (2) @(negedge ref_clk);
    reset = 1'b0;
    test_translate();
    test_stack();
    test_list();
    print_verdict();
  end
endmodule
`default_nettype wire

// ===== verification/tle_mem_model.sv
// Purpose: behavioural main memory seen by the translate and list unit
// Assumes: one outstanding read at a time; writes land on the request edge
// Notes:   slow=1 stretches read latency so the unit must really wait
`timescale 1ns/1ps
`default_nettype none
module tle_mem_model
  import tle_pkg::*;
(
  // clock
  input  wire logic              ref_clk,
  // latency select
  input  wire logic              slow,
  // memory port
  input  wire tle_mem_req_t      mem_req,
  output var  logic              mem_rd_valid,
  output var  logic [WORD_W-1:0] mem_rdata
);
  logic [WORD_W-1:0] mem [0:32767];
  logic [ADDR_W-1:0] addr_q;
  logic [2:0]        wait_q;
  logic              pend_q;

  initial begin
    pend_q       = 1'b0;
    mem_rd_valid = 1'b0;
    mem_rdata    = 24'h000000;
  end

  // -----------------------------------------------------------------
  // read and write service
  // -----------------------------------------------------------------
  // outside a valid beat the data lines toggle, so stale data never passes
  always @(posedge ref_clk) begin
    mem_rd_valid <= 1'b0;
    mem_rdata    <= ~mem_rdata;
    if (mem_req.valid && mem_req.write) begin
      mem[mem_req.addr] <= mem_req.wdata;
    end
    if (mem_req.valid && !mem_req.write) begin
      pend_q <= 1'b1;
      addr_q <= mem_req.addr;
      wait_q <= slow ? 3'h4 : 3'h0;
    end else if (pend_q) begin
      if (wait_q == 3'h0) begin
        mem_rd_valid <= 1'b1;
        mem_rdata    <= mem[addr_q];
        pend_q       <= 1'b0;
      end else begin
        wait_q <= wait_q - 3'h1;
      end
    end
  end
endmodule
`default_nettype wire
